// ### sxs_pkg.sv
package sxs_pkg;

    // ------------------------------------------------------------------
    // Bus and data widths
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W  = 12;           // APB byte address width.
    localparam int unsigned DATA_W  = 32;           // APB data width.
    localparam int unsigned BYTE_W  = 8;            // Datapath width.
    localparam int unsigned FADDR_W = 7;            // File address width.
    localparam int unsigned FILE_N  = 128;          // Number of file registers.

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CMD    = 12'h000; // Command, write executes.
    localparam logic [ADDR_W-1:0] OFS_ACC    = 12'h004; // Accumulator.
    localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h008; // Status flags.
    localparam logic [ADDR_W-1:0] OFS_RESULT = 12'h00C; // Last result, read only.
    localparam logic [2:0]        FILE_SEL   = 3'h1;    // Window at 0x200..0x3FC.

    // ------------------------------------------------------------------
    // Command register field positions
    // ------------------------------------------------------------------
    localparam int unsigned CMD_OP_LSB   = 0;       // Opcode, two bits.
    localparam int unsigned CMD_DEST_BIT = 4;       // Destination select.
    localparam int unsigned CMD_FA_LSB   = 8;       // File address, seven bits.
    localparam int unsigned CMD_LIT_LSB  = 16;      // Literal, eight bits.

    // ------------------------------------------------------------------
    // Status register field positions
    // ------------------------------------------------------------------
    localparam int unsigned ST_CARRY_BIT = 0;       // Carry flag.
    localparam int unsigned ST_HALF_BIT  = 1;       // Half flag (low nibble carry).
    localparam int unsigned ST_ZERO_BIT  = 2;       // Zero flag.

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [BYTE_W-1:0] ACC_RST    = 8'h00; // Accumulator after reset.
    localparam logic [BYTE_W-1:0] FILE_RST   = 8'h00; // Each file register.
    localparam logic [DATA_W-1:0] CMD_RST    = 32'h0000_0000; // Command readback.
    localparam logic [BYTE_W-1:0] RESULT_RST = 8'h00; // Last result.

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    // Operation codes held in the command register.
    typedef enum logic [1:0] {
        OP_SUB_ACC_FROM_REG     = 2'h0,
        OP_XOR_ACC_WITH_REG     = 2'h1,
        OP_NIBBLE_EXCHANGE      = 2'h2,
        OP_XOR_ACC_WITH_LITERAL = 2'h3
    } sxs_op_e;

    // Status flags travel together.
    typedef struct packed {
        logic zero;
        logic half_flag;
        logic carry;
    } sxs_flags_s;

    // One operation request for the arithmetic unit.
    typedef struct packed {
        sxs_op_e             op;
        logic [BYTE_W-1:0]   acc;
        logic [BYTE_W-1:0]   freg;
        logic [BYTE_W-1:0]   lit;
        sxs_flags_s          flags;
    } sxs_req_s;

    // Answer of the arithmetic unit.
    typedef struct packed {
        logic [BYTE_W-1:0]   res;
        sxs_flags_s          flags;
    } sxs_rsp_s;

endpackage : sxs_pkg

// ### sxs_alu.sv
// Pure combinational arithmetic unit for the four operations.
module sxs_alu
    import sxs_pkg::*;
(
    // Request in.
    input  wire sxs_req_s req,
    // Answer out.
    output sxs_rsp_s      rsp
);

    // ------------------------------------------------------------------
    // Subtraction as addition of the complement
    // ------------------------------------------------------------------
    logic [BYTE_W:0] diff;   // Nine bits, top bit is the carry (no borrow).
    logic [4:0]      ndiff;  // Low nibble difference, top bit is half flag.

    // Adding the complement plus one gives a carry of one exactly when
    // the accumulator is not above the register, so no compare is needed.
    always_comb begin
        diff  = {1'b0, req.freg} + {1'b0, ~req.acc} + 9'h001;
        ndiff = {1'b0, req.freg[3:0]} + {1'b0, ~req.acc[3:0]} + 5'h01;
    end

    // ------------------------------------------------------------------
    // Result and flag selection
    // ------------------------------------------------------------------
    // Flags not touched by an operation pass through unchanged.
    always_comb begin
        rsp.flags = req.flags;
        case (req.op)
            OP_SUB_ACC_FROM_REG: begin
                rsp.res             = diff[BYTE_W-1:0];
                rsp.flags.carry     = diff[BYTE_W];
                rsp.flags.half_flag = ndiff[4];
            end
            OP_XOR_ACC_WITH_REG: begin
                rsp.res = req.acc ^ req.freg;
            end
            OP_NIBBLE_EXCHANGE: begin
                rsp.res = {req.freg[3:0], req.freg[7:4]};
            end
            default: begin
                rsp.res = req.acc ^ req.lit;
            end
        endcase
        // The exchange leaves every flag alone; the others all touch zero.
        if (req.op != OP_NIBBLE_EXCHANGE) begin
            rsp.flags.zero = (rsp.res == 8'h00);
        end
    end

endmodule : sxs_alu

// ### sxs_core.sv
// Our own choices: the APB slave port and the register addresses.
module sxs_core
    import sxs_pkg::*;
(
    // Clock and reset.
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB request.
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    // APB answer.
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    // All storage of the slice, file registers included, lives in this
    // one struct so that reset and update stay in a single place.
    typedef struct packed {
        logic [FILE_N-1:0][BYTE_W-1:0] file;    // File registers.
        logic [BYTE_W-1:0]             acc;     // Accumulator.
        sxs_flags_s                    flags;   // Carry, half and zero.
        logic [BYTE_W-1:0]             result;  // Last computed result.
        logic [DATA_W-1:0]             cmd;     // Last command written.
        logic [DATA_W-1:0]             prdata;  // Read data for the access.
        logic                          pready;  // Access phase answer.
        logic                          pslverr; // Unmapped address answer.
    } sxs_state_s;

    sxs_state_s s_q;  // Registered state.
    sxs_state_s s_d;  // Next state.

    // ------------------------------------------------------------------
    // Command decode from the write data
    // ------------------------------------------------------------------
    sxs_op_e            cmd_op;     // Operation requested.
    logic               cmd_dest;   // Destination select.
    logic [FADDR_W-1:0] cmd_faddr;  // File address of the operand.
    logic [BYTE_W-1:0]  cmd_lit;    // Immediate operand.
    sxs_req_s           alu_req;    // Operands for the arithmetic unit.
    sxs_rsp_s           alu_rsp;    // Result and new flags.

    // Fields are taken straight from the bus so the command runs in the
    // same edge that completes its write; no second cycle is needed.
    always_comb begin
        cmd_op    = sxs_op_e'(pwdata[CMD_OP_LSB +: 2]);
        cmd_dest  = pwdata[CMD_DEST_BIT];
        cmd_faddr = pwdata[CMD_FA_LSB +: FADDR_W];
        cmd_lit   = pwdata[CMD_LIT_LSB +: BYTE_W];
        alu_req.op    = cmd_op;
        alu_req.acc   = s_q.acc;
        alu_req.freg  = s_q.file[cmd_faddr];
        alu_req.lit   = cmd_lit;
        alu_req.flags = s_q.flags;
    end

    // ------------------------------------------------------------------
    // Arithmetic unit
    // ------------------------------------------------------------------
    sxs_alu u_alu (
        .req (alu_req),
        .rsp (alu_rsp)
    );

    // ------------------------------------------------------------------
    // Bus phase decode
    // ------------------------------------------------------------------
    logic setup_ph;   // Setup cycle, answer not yet given.
    logic access_ph;  // Access cycle that completes this edge.
    logic is_file;    // Address falls in the file window.
    logic [FADDR_W-1:0] win_idx;  // File index from the bus address.

    // The answer is one access cycle long; the setup edge prepares it.
    always_comb begin
        setup_ph  = psel && !penable && !s_q.pready;
        access_ph = psel && penable && s_q.pready;
        is_file   = (paddr[11:9] == FILE_SEL);
        win_idx   = paddr[8:2];
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d         = s_q;
        s_d.pready  = 1'b0;
        s_d.pslverr = 1'b0;

        // Setup edge: raise ready, load read data and decide the error.
        if (setup_ph) begin
            s_d.pready = 1'b1;
            s_d.prdata = '0;
            if (paddr == OFS_CMD) begin
                s_d.prdata = s_q.cmd;
            end else if (paddr == OFS_ACC) begin
                s_d.prdata[BYTE_W-1:0] = s_q.acc;
            end else if (paddr == OFS_STATUS) begin
                s_d.prdata[ST_CARRY_BIT] = s_q.flags.carry;
                s_d.prdata[ST_HALF_BIT]  = s_q.flags.half_flag;
                s_d.prdata[ST_ZERO_BIT]  = s_q.flags.zero;
            end else if (paddr == OFS_RESULT) begin
                s_d.prdata[BYTE_W-1:0] = s_q.result;
            end else if (is_file && (paddr[1:0] == 2'h0)) begin
                s_d.prdata[BYTE_W-1:0] = s_q.file[win_idx];
            end else begin
                // Unmapped or misaligned: error answer, nothing changes.
                s_d.pslverr = 1'b1;
            end
        end

        // Access edge: a write takes effect here and nowhere else.
        if (access_ph && pwrite && !s_q.pslverr) begin
            if (paddr == OFS_CMD) begin
                s_d.cmd    = pwdata;
                s_d.result = alu_rsp.res;
                s_d.flags  = alu_rsp.flags;
                // Literal XOR always lands in the accumulator; the
                // register forms follow the destination bit.
                if (cmd_op == OP_XOR_ACC_WITH_LITERAL) begin
                    s_d.acc = alu_rsp.res;
                end else if (cmd_dest == 1'b0) begin
                    s_d.acc = alu_rsp.res;
                end else begin
                    s_d.file[cmd_faddr] = alu_rsp.res;
                end
            end else if (paddr == OFS_ACC) begin
                s_d.acc = pwdata[BYTE_W-1:0];
            end else if (paddr == OFS_STATUS) begin
                s_d.flags.carry     = pwdata[ST_CARRY_BIT];
                s_d.flags.half_flag = pwdata[ST_HALF_BIT];
                s_d.flags.zero      = pwdata[ST_ZERO_BIT];
            end else if (is_file) begin
                s_d.file[win_idx] = pwdata[BYTE_W-1:0];
            end else begin
                // The result register is read only; a write is dropped.
                s_d.result = s_q.result;
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Every field resets to a constant; the file clears as a whole.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q.file    <= {FILE_N{FILE_RST}};
            s_q.acc     <= ACC_RST;
            s_q.flags   <= '0;
            s_q.result  <= RESULT_RST;
            s_q.cmd     <= CMD_RST;
            s_q.prdata  <= '0;
            s_q.pready  <= 1'b0;
            s_q.pslverr <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Straight from flip-flops, so the bus sees no decode glitches.
    assign prdata  = s_q.prdata;
    assign pready  = s_q.pready;
    assign pslverr = s_q.pslverr;

endmodule : sxs_core

// ### sxs_core_properties.sv
module sxs_core_props
    import sxs_pkg::*;
(
    // Clock and reset.
    input wire logic              pclk,
    input wire logic              presetn,
    // Bus request.
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    // Bus answer.
    input wire logic [DATA_W-1:0] prdata,
    input wire logic              pready,
    input wire logic              pslverr
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // Bus phases
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // A setup cycle opens every transfer.
    sequence s_setup;
        psel && !penable;
    endsequence
    // An aligned read inside the file window.
    sequence s_file_rd;
        s_setup ##0 (!pwrite && paddr[11:9] == FILE_SEL && paddr[1:0] == 2'h0);
    endsequence
    // A misaligned access inside the file window must be refused.
    sequence s_file_bad;
        s_setup ##0 (paddr[11:9] == FILE_SEL && paddr[1:0] != 2'h0);
    endsequence

    a_ready_next:
        assert property (s_setup |=> pready) else $error("No answer after setup.");
    a_ready_pulse:
        assert property (pready |=> !pready) else $error("Ready held too long.");
    a_ready_access:
        assert property (pready |-> psel && penable) else $error("Ready outside access.");
    a_err_ready:
        assert property (pslverr |-> pready) else $error("Error without ready.");
    a_idle_quiet:
        assert property (!psel |=> !pready) else $error("Ready while idle.");
    a_file_upper:
        assert property (s_file_rd |=> !pslverr && prdata[31:8] == 24'h0)
        else $error("File read refused or upper bits set.");
    a_file_bad:
        assert property (s_file_bad |=> pslverr) else $error("Misaligned not refused.");
    a_status_width:
        assert property (s_setup ##0 (!pwrite && paddr == OFS_STATUS)
                         |=> prdata[31:3] == 29'h0) else $error("Status upper bits set.");
endmodule : sxs_core_props

// ### tb_top.sv
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end

module tb_top
    import sxs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // One operation with its operands and the flags it starts from.
    typedef struct packed {
        sxs_op_e    op;
        logic       d;
        logic [6:0] fa;
        logic [7:0] f;
        logic [7:0] w;
        logic [7:0] k;
        logic [2:0] st;
    } sxs_tbvec_s;

    logic              pclk = 1'b0;
    logic              presetn = 1'b0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] rd;        // Data of the last transfer.
    logic              er;        // Error of the last transfer.
    int                miscompares = 0;
    int                num_checks = 0;
    int                cyc = 0;
    // Boundary addresses, equal operands and zero results are the awkward cases.
    sxs_tbvec_s vec [9] = '{
        '{OP_SUB_ACC_FROM_REG, 1'b0, 7'h00, 8'h3A, 8'h1A, 8'h00, 3'h0},
        '{OP_SUB_ACC_FROM_REG, 1'b1, 7'h7F, 8'h10, 8'h21, 8'h00, 3'h7},
        '{OP_SUB_ACC_FROM_REG, 1'b0, 7'h09, 8'h55, 8'h55, 8'h00, 3'h0},
        '{OP_XOR_ACC_WITH_REG, 1'b1, 7'h03, 8'hA5, 8'hA5, 8'h00, 3'h3},
        '{OP_XOR_ACC_WITH_REG, 1'b0, 7'h04, 8'h0F, 8'hF0, 8'h00, 3'h4},
        '{OP_NIBBLE_EXCHANGE, 1'b1, 7'h40, 8'hC3, 8'h11, 8'h00, 3'h5},
        '{OP_NIBBLE_EXCHANGE, 1'b0, 7'h01, 8'h00, 8'h22, 8'h00, 3'h2},
        '{OP_XOR_ACC_WITH_LITERAL, 1'b1, 7'h02, 8'h77, 8'h5A, 8'h5A, 3'h3},
        '{OP_XOR_ACC_WITH_LITERAL, 1'b0, 7'h05, 8'h66, 8'h00, 8'hFF, 3'h4}
    };

    sxs_core i_sxs_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    // ------------------------------------------------------------------
    // Clock and watchdog
    // ------------------------------------------------------------------
    initial begin
        forever #12.5 pclk = ~pclk;
    end
    // About 90 transfers of three cycles fit well inside this ceiling.
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            final_report();
        end
    end

    // One bus transfer; answer is taken at the edge that sees ready high.
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Request stands until a rising edge samples ready high; data and error are taken there.
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Loads operands, executes, and compares every visible effect.
    task automatic run_vec(input sxs_tbvec_s v);
        logic [7:0]        res;
        logic [2:0]        st;
        logic [ADDR_W-1:0] fad;
        logic [DATA_W-1:0] cw;
        st = v.st;
        fad = {FILE_SEL, v.fa, 2'h0};
        cw = {8'h0, v.k, 1'b0, v.fa, 3'h0, v.d, 2'h0, v.op};
        case (v.op)
            OP_SUB_ACC_FROM_REG: begin
                res = v.f - v.w;
                st = {res == 8'h00, v.w[3:0] <= v.f[3:0], v.w <= v.f};
            end
            OP_XOR_ACC_WITH_REG: res = v.f ^ v.w;
            OP_NIBBLE_EXCHANGE: res = {v.f[3:0], v.f[7:4]};
            default: res = v.w ^ v.k;
        endcase
        if (v.op == OP_XOR_ACC_WITH_REG || v.op == OP_XOR_ACC_WITH_LITERAL) st[2] = res == 8'h00;
        apb(1'b1, fad, {24'h0, v.f});
        apb(1'b1, OFS_ACC, {24'h0, v.w});
        apb(1'b1, OFS_STATUS, {29'h0, v.st});
        apb(1'b1, OFS_CMD, cw);
        `CHK(er, 1'b0)
        apb(1'b0, OFS_ACC, '0);
        `CHK(rd, {24'h0, (v.op == OP_XOR_ACC_WITH_LITERAL || !v.d) ? res : v.w})
        apb(1'b0, fad, '0);
        `CHK(rd, {24'h0, (v.op != OP_XOR_ACC_WITH_LITERAL && v.d) ? res : v.f})
        apb(1'b0, OFS_STATUS, '0);
        `CHK(rd, {29'h0, st})
        apb(1'b0, OFS_RESULT, '0);
        `CHK(rd, {24'h0, res})
        // The command word reads back whole, fields where they were written.
        apb(1'b0, OFS_CMD, '0);
        `CHK(rd, cw)
    endtask : run_vec

    // Prints the counts and the verdict, then stops.
    task automatic final_report();
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        foreach (vec[i]) begin
            apb(1'b0, i == 0 ? OFS_ACC : i == 1 ? OFS_STATUS : OFS_RESULT, '0);
            `CHK(rd, 32'h0)
            if (i == 2) break;
        end
        foreach (vec[i]) run_vec(vec[i]);
        // Unmapped and misaligned places are refused; the result is read only.
        apb(1'b0, 12'h010, '0);
        `CHK(er, 1'b1)
        apb(1'b1, 12'h206, 32'h0000_00AB);
        `CHK(er, 1'b1)
        apb(1'b1, OFS_RESULT, 32'h0000_0012);
        apb(1'b0, OFS_RESULT, '0);
        `CHK(rd, 32'h0000_00FF)
        final_report();
    end
endmodule : tb_top

bind sxs_core sxs_core_props i_sxs_core_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
